/* logic/pscl_pkg.sv */
// shared constants and types of the passive serial configuration loader
`default_nettype none
package pscl_pkg;

  // clock rate and derived timing
  localparam int unsigned CLK_FREQ_MHZ = 250;
  localparam int unsigned POR_TIME_MS = 100;
  localparam int unsigned POR_CYCLES = POR_TIME_MS * 1000 * CLK_FREQ_MHZ;
  // longest restart time-out, rounded down
  localparam int unsigned RESTART_TIME_US = 40;
  localparam int unsigned RESTART_CYCLES = RESTART_TIME_US * CLK_FREQ_MHZ;
  // internal startup oscillator, one tick per oscillator period
  localparam int unsigned OSC_FREQ_MHZ = 10;
  localparam int unsigned OSC_DIV = CLK_FREQ_MHZ / OSC_FREQ_MHZ;
  localparam int unsigned INIT_CYCLES = 299;

  // bitstream layout
  localparam int unsigned CFG_BITS_DEF = 1024;
  localparam int unsigned FRAME_BITS_DEF = 64;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned WORD_LSB_W = 5;
  localparam int unsigned SYNC_W = 16;
  localparam logic [SYNC_W-1:0] SYNC_PATTERN = 16'h6A5C;
  localparam int unsigned INIT_EN_POS = 16;

  // loader states, gray coded along the normal path
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_RESET = 3'h1,
    ST_CONFIG = 3'h3,
    ST_WAIT_DONE = 3'h2,
    ST_INIT = 3'h6,
    ST_USER = 3'h7,
    ST_ERROR = 3'h5
  } pscl_state_type;

  // option bits held by the surrounding device
  typedef struct packed {
    logic user_clock_en;
    logic auto_restart;
  } pscl_opt_type;

  // user i/o pad control
  typedef struct packed {
    logic tristate;
    logic pullup_en;
    logic user_mode;
  } pscl_io_type;

  // indices into the synchroniser vector
  localparam int unsigned SYN_N = 6;
  localparam int unsigned SYN_RCFG = 0;
  localparam int unsigned SYN_STAT = 1;
  localparam int unsigned SYN_DONE = 2;
  localparam int unsigned SYN_DCLK = 3;
  localparam int unsigned SYN_DATA = 4;
  localparam int unsigned SYN_UCLK = 5;
  localparam logic [SYN_N-1:0] SYN_RST = 6'h00;

endpackage : pscl_pkg
`default_nettype wire

/* logic/pscl_cfg_mem.sv */
// configuration word store with registered read port
`default_nettype none
module pscl_cfg_mem #(
  parameter int unsigned DW = 32,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_reg [DEPTH];

  // array itself has no reset, only its read register does
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule : pscl_cfg_mem
`default_nettype wire

/* logic/pscl_loader.sv */
// passive serial configuration loader, device side
//
// Function
// - power-on reset holds status and load-complete low, user pins tri-stated.
// - after power-on interval release status; configure once status reads high.
// - reconfigure request rising starts reset, configuration, initialization in order.
// - stay in reset while request or status line is low.
// - request high releases status; then accept configuration data.
// - capture each data bit on rising serial bit clock.
// - all bits in, sync word good: release load-complete; its rise starts initialization.
// - default initialization runs from internal oscillator, needing no outside clock.
// - user startup clock option: 299 clock cycles after load-complete rises.
// - with that option wait for the clock forever; configuration ignores it.
// - startup-finished driven low once enabled in first frame, released in user mode.
// - shared load-complete lines make chained devices initialize together.
// - pull-ups and tri-state until user mode, then design-owned pins.
// - request low pulls status and load-complete low and tri-states pins.
// - error drives status low; auto-restart releases it within 40 us.
`default_nettype none
module pscl_loader
  import pscl_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned RESTART_CNT = RESTART_CYCLES,
  parameter int unsigned CFG_BITS = CFG_BITS_DEF,
  parameter int unsigned FRAME_BITS = FRAME_BITS_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // reconfigure request and options
  input wire logic reconfig_b_i,
  input wire pscl_opt_type opt_i,
  // open-drain status line
  input wire logic status_i,
  output logic status_o,
  output logic status_oe_b_o,
  // open-drain load-complete line
  input wire logic load_done_i,
  output logic load_done_o,
  output logic load_done_oe_b_o,
  // serial stream from the configuration memory, and the user startup clock
  input wire logic serial_bit_clock_i,
  input wire logic serial_bit_in_i,
  input wire logic user_startup_clock_i,
  // open-drain startup-finished line
  output logic init_done_o,
  output logic init_done_oe_b_o,
  // chain and user pin control
  output logic chain_enable_out_low_o,
  output pscl_io_type io_ctrl_o,
  output logic cfg_error_o,
  // readback of loaded words
  input wire logic [$clog2(CFG_BITS/WORD_W)-1:0] rd_addr_i,
  output logic [WORD_W-1:0] rd_data_o
);

  localparam int unsigned WORDS = CFG_BITS / WORD_W;
  localparam int unsigned AW = $clog2(WORDS);
  localparam int unsigned BW = $clog2(CFG_BITS + 1);
  localparam int unsigned TW = 32;
  localparam int unsigned IW = 9;
  localparam int unsigned OW = 5;

  if (CFG_BITS % WORD_W != 0 || WORDS < 2) begin : g_bad_len
    $error("CFG_BITS must be a multiple of 32, at least 64");
  end
  if (INIT_EN_POS >= FRAME_BITS || FRAME_BITS > CFG_BITS) begin : g_bad_frm
    $error("frame too short for enable bit or longer than stream");
  end
  if (POR_CNT < 1 || RESTART_CNT < 1) begin : g_bad_cnt
    $error("timing counts must be at least one cycle");
  end

  pscl_state_type state_reg, state_next;
  logic [SYN_N-1:0] raw, syn1_reg, syn2_reg, prev_reg;
  logic [TW-1:0] tmr_reg;
  logic [BW-1:0] bit_cnt_reg;
  logic [WORD_W-1:0] word_reg, wr_word;
  logic [IW-1:0] init_cnt_reg;
  logic [OW-1:0] osc_div_reg;
  logic init_en_reg, status_drv_reg, load_drv_reg, init_drv_reg, chain_reg;
  pscl_io_type io_reg;
  logic err_reg, rcfg_low, status_hi, done_hi, dclk_rise, ucl_rise, data_bit;
  logic sync_bad, last_bit, osc_tick, init_tick, wr_en;

  assign raw = {user_startup_clock_i, serial_bit_in_i, serial_bit_clock_i,
                load_done_i, status_i, reconfig_b_i};

  // every outside input except opt_i and rd_addr_i passes two flops before any logic
  for (genvar g = 0; g < SYN_N; g++) begin : g_sync
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        syn1_reg[g] <= SYN_RST[g];
        syn2_reg[g] <= SYN_RST[g];
        prev_reg[g] <= SYN_RST[g];
      end else begin
        syn1_reg[g] <= raw[g];
        syn2_reg[g] <= syn1_reg[g];
        prev_reg[g] <= syn2_reg[g];
      end
    end
  end

  assign rcfg_low = !syn2_reg[SYN_RCFG];
  assign status_hi = syn2_reg[SYN_STAT];
  assign done_hi = syn2_reg[SYN_DONE];
  // bit clock sampled at 4 ns; edges found from the synchronised copy
  assign dclk_rise = syn2_reg[SYN_DCLK] && !prev_reg[SYN_DCLK];
  assign ucl_rise = syn2_reg[SYN_UCLK] && !prev_reg[SYN_UCLK];
  assign data_bit = syn2_reg[SYN_DATA];
  assign sync_bad = (bit_cnt_reg < BW'(SYNC_W)) &&
                    (data_bit != SYNC_PATTERN[bit_cnt_reg[3:0]]);
  assign last_bit = bit_cnt_reg == BW'(CFG_BITS - 1);
  assign osc_tick = osc_div_reg == OW'(OSC_DIV - 1);
  // user clock edges count only while initializing
  assign init_tick = opt_i.user_clock_en ? ucl_rise : osc_tick;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: begin
        if (tmr_reg == TW'(POR_CNT - 1)) begin
          state_next = ST_RESET;
        end
      end
      ST_RESET: begin
        // leave only with request high and the shared line released
        if (!rcfg_low && status_hi) begin
          state_next = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (!status_hi) begin
          state_next = ST_RESET;
        end else if (dclk_rise && sync_bad) begin
          state_next = ST_ERROR;
        end else if (dclk_rise && last_bit) begin
          state_next = ST_WAIT_DONE;
        end
      end
      ST_WAIT_DONE: begin
        // wired line rises only when every chained device released it
        if (!status_hi) begin
          state_next = ST_RESET;
        end else if (done_hi) begin
          state_next = ST_INIT;
        end
      end
      ST_INIT: begin
        if (!status_hi) begin
          state_next = ST_RESET;
        end else if (init_tick && init_cnt_reg == IW'(INIT_CYCLES - 1)) begin
          state_next = ST_USER;
        end
      end
      ST_USER: begin
        state_next = ST_USER;
      end
      ST_ERROR: begin
        if (opt_i.auto_restart && tmr_reg == TW'(RESTART_CNT - 1)) begin
          state_next = ST_RESET;
        end
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
    if (state_reg != ST_POR && rcfg_low) begin
      state_next = ST_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // shared timer for power-on and restart intervals
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmr_reg <= '0;
    end else if (state_next != state_reg) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_reg + TW'(1);
    end
  end

  // serial capture, LSB first into 32-bit words
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_reg <= '0;
      word_reg <= '0;
    end else if (state_reg != ST_CONFIG) begin
      bit_cnt_reg <= '0;
    end else if (dclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + BW'(1);
      word_reg <= wr_word;
    end
  end
  assign wr_word = {data_bit, word_reg[WORD_W-1:1]};
  assign wr_en = (state_reg == ST_CONFIG) && dclk_rise &&
                 (bit_cnt_reg[WORD_LSB_W-1:0] == '1);

  // enable bit for startup-finished arrives inside the first frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      init_en_reg <= 1'h0;
    end else if (state_reg == ST_RESET) begin
      init_en_reg <= 1'h0;
    end else if (state_reg == ST_CONFIG && dclk_rise &&
                 bit_cnt_reg == BW'(INIT_EN_POS) && data_bit) begin
      init_en_reg <= 1'h1;
    end
  end

  // internal oscillator and initialization cycle count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_div_reg <= '0;
      init_cnt_reg <= '0;
    end else if (state_reg != ST_INIT) begin
      osc_div_reg <= '0;
      init_cnt_reg <= '0;
    end else begin
      osc_div_reg <= osc_tick ? '0 : osc_div_reg + OW'(1);
      if (init_tick) begin
        init_cnt_reg <= init_cnt_reg + IW'(1);
      end
    end
  end

  // pin drives, registered from the next state so they track transitions
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_drv_reg <= 1'h1;
      load_drv_reg <= 1'h1;
      init_drv_reg <= 1'h0;
      chain_reg <= 1'h1;
      io_reg <= '{tristate: 1'h1, pullup_en: 1'h1, user_mode: 1'h0};
      err_reg <= 1'h0;
    end else begin
      status_drv_reg <= state_next == ST_POR || state_next == ST_ERROR ||
                        (state_next == ST_RESET && rcfg_low);
      load_drv_reg <= !(state_next == ST_WAIT_DONE ||
                        state_next == ST_INIT ||
                        state_next == ST_USER);
      init_drv_reg <= init_en_reg && (state_next == ST_CONFIG ||
                      state_next == ST_WAIT_DONE ||
                      state_next == ST_INIT);
      chain_reg <= !(state_next == ST_WAIT_DONE ||
                     state_next == ST_INIT || state_next == ST_USER);
      io_reg.tristate <= state_next != ST_USER;
      io_reg.pullup_en <= state_next != ST_USER;
      io_reg.user_mode <= state_next == ST_USER;
      err_reg <= state_next == ST_ERROR;
    end
  end

  // open-drain pins only ever pull low
  assign status_o = 1'h0;
  assign status_oe_b_o = !status_drv_reg;
  assign load_done_o = 1'h0;
  assign load_done_oe_b_o = !load_drv_reg;
  assign init_done_o = 1'h0;
  assign init_done_oe_b_o = !init_drv_reg;
  assign chain_enable_out_low_o = chain_reg;
  assign io_ctrl_o = io_reg;
  assign cfg_error_o = err_reg;

  pscl_cfg_mem #(
    .DW(WORD_W),
    .DEPTH(WORDS),
    .AW(AW)
  ) u_mem (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_en),
    .wr_addr_i(bit_cnt_reg[WORD_LSB_W +: AW]),
    .wr_data_i(wr_word),
    .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o)
  );

endmodule : pscl_loader
`default_nettype wire

/* verification/pscl_loader_assertions.sv */
// concurrent checks on the loader pins
`default_nettype none
module pscl_loader_assertions
  import pscl_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_CYCLES,
  parameter int unsigned RESTART_CNT = RESTART_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // inputs
  input wire logic reconfig_b_i,
  input wire pscl_opt_type opt_i,
  input wire logic load_done_i,
  input wire logic user_startup_clock_i,
  // outputs
  input wire logic status_o,
  input wire logic load_done_o,
  input wire logic init_done_o,
  input wire logic status_oe_b_o,
  input wire logic load_done_oe_b_o,
  input wire logic init_done_oe_b_o,
  input wire logic chain_enable_out_low_o,
  input wire pscl_io_type io_ctrl_o,
  input wire logic cfg_error_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  int unsigned por_cnt, init_cnt, uclk_cnt, err_cnt;
  logic uclk_q;
  // raw pin counts run ahead of the synchronised ones, so bounds are loose
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_cnt <= 0;
      init_cnt <= 0;
      uclk_cnt <= 0;
      err_cnt <= 0;
      uclk_q <= 1'b0;
    end else begin
      uclk_q <= user_startup_clock_i;
      if (por_cnt < POR_CNT) por_cnt <= por_cnt + 1;
      err_cnt <= cfg_error_o ? err_cnt + 1 : 0;
      if (!load_done_i || !reconfig_b_i) begin
        init_cnt <= 0;
        uclk_cnt <= 0;
      end else if (!io_ctrl_o.user_mode) begin
        init_cnt <= init_cnt + 1;
        uclk_cnt <= uclk_cnt + 32'(user_startup_clock_i & !uclk_q);
      end
    end
  end
  property p_por_hold;
    por_cnt + 2 < POR_CNT |-> !status_oe_b_o && !load_done_oe_b_o &&
      io_ctrl_o.tristate && io_ctrl_o.pullup_en;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("pins not held in power-on");
  property p_rcfg_low;
    !reconfig_b_i [*5] |-> !status_oe_b_o && !load_done_oe_b_o &&
      io_ctrl_o.tristate;
  endproperty
  a_rcfg_low: assert property (p_rcfg_low)
    else $error("request low not obeyed");
  property p_user_io;
    io_ctrl_o.user_mode |-> !io_ctrl_o.tristate && !io_ctrl_o.pullup_en &&
      load_done_oe_b_o && init_done_oe_b_o && !chain_enable_out_low_o;
  endproperty
  a_user_io: assert property (p_user_io)
    else $error("bad pins in user mode");
  property p_done_first;
    $rose(load_done_oe_b_o) |-> !chain_enable_out_low_o &&
      !io_ctrl_o.user_mode && status_oe_b_o;
  endproperty
  a_done_first: assert property (p_done_first)
    else $error("load-complete released out of order");
  property p_osc_init;
    !opt_i.user_clock_en && !io_ctrl_o.user_mode |-> init_cnt <= 7500;
  endproperty
  a_osc_init: assert property (p_osc_init)
    else $error("internal startup too long");
  property p_init_rise;
    $rose(io_ctrl_o.user_mode) |->
      (opt_i.user_clock_en ? uclk_cnt >= 299 : init_cnt >= 7440);
  endproperty
  a_init_rise: assert property (p_init_rise)
    else $error("user mode entered early");
  property p_err;
    $past(cfg_error_o) && cfg_error_o |-> !status_oe_b_o &&
      (!opt_i.auto_restart || err_cnt <= RESTART_CNT + 4);
  endproperty
  a_err: assert property (p_err)
    else $error("error handling wrong");
  property p_init_done;
    $fell(init_done_oe_b_o) |-> chain_enable_out_low_o && !load_done_oe_b_o;
  endproperty
  a_init_done: assert property (p_init_done)
    else $error("startup-finished driven late");
  property p_od_low;
    !status_o && !load_done_o && !init_done_o;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain data not low");
endmodule : pscl_loader_assertions
`default_nettype wire

/* verification/pscl_mem_model.sv */
// serial configuration memory model with its own bit clock
`default_nettype none
module pscl_mem_model #(
  parameter int N = 64,
  parameter int POR_LONG_NS = 400,
  parameter int POR_SHORT_NS = 100
) (
  // lines seen by the memory
  input wire logic oe_i,
  input wire logic cs_b_i,
  input wire logic power_on_delay_select_i,
  input wire logic [N-1:0] image_i,
  // lines driven by the memory
  output logic oe_b_o,
  output logic dclk_o,
  output logic data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic abort = 1'b0;
  always @(negedge oe_i) abort = 1'b1;
  initial begin
    dclk_o = 1'b0;
    data_o = 1'b1;
    oe_b_o = 1'b0;
    #(power_on_delay_select_i ? POR_SHORT_NS : POR_LONG_NS);
    oe_b_o = 1'b1;
    forever begin
      wait (oe_i && !cs_b_i);
      abort = 1'b0;
      #1000;
      for (int i = 0; i < N && !abort && !cs_b_i; i++) begin
        data_o = image_i[i];
        #62.5 dclk_o = 1'b1;
        #62.5 dclk_o = 1'b0;
      end
      data_o = 1'b1;
      wait (abort || cs_b_i);
    end
  end
endmodule : pscl_mem_model
`default_nettype wire

/* verification/pscl_loader_test.sv */
// loader testbench with memory model and reference readback
`default_nettype none
module pscl_loader_test;
  timeunit 1ns;
  timeprecision 100ps;
  import pscl_pkg::*;
  localparam int NB = 64;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic rcfg = 1'b1;
  logic uclk = 1'b0;
  logic [0:0] ra = 1'b0;
  pscl_opt_type opt = '0;
  logic [NB-1:0] img = '0;
  logic [15:0] lfsr = 16'h0029;
  logic st_oe_b, ld_oe_b, m_oe_b, dclk, din, cen, err, ido;
  logic [WORD_W-1:0] rd;
  pscl_io_type io;
  wire logic status = st_oe_b & m_oe_b;
  wire logic ld = ld_oe_b;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2 clk_i = ~clk_i;
  pscl_loader #(.POR_CNT(50), .RESTART_CNT(20), .CFG_BITS(NB)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reconfig_b_i(rcfg), .opt_i(opt),
    .status_i(status), .status_o(), .status_oe_b_o(st_oe_b),
    .load_done_i(ld), .load_done_o(), .load_done_oe_b_o(ld_oe_b),
    .serial_bit_clock_i(dclk), .serial_bit_in_i(din),
    .user_startup_clock_i(uclk), .init_done_o(),
    .init_done_oe_b_o(ido), .chain_enable_out_low_o(cen), .io_ctrl_o(io),
    .cfg_error_o(err), .rd_addr_i(ra), .rd_data_o(rd));
  pscl_mem_model #(.N(NB)) mem_u (.oe_i(status), .cs_b_i(ld),
    .power_on_delay_select_i(1'b0), .image_i(img), .oe_b_o(m_oe_b),
    .dclk_o(dclk), .data_o(din));
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  function automatic logic sig(int w);
    return w == 0 ? ld : w == 1 ? io.user_mode : err;
  endfunction : sig
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic wait_sig(int w);
    for (int i = 0; i < 9000 && sig(w) !== 1'b1; i++) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wait_sig
  task automatic new_img(logic ie);
    for (int k = 1; k < 4; k++) begin
      lfsr = nxt(lfsr);
      img[16*k +: 16] = lfsr;
    end
    img[16] = ie;
    img[15:0] = SYNC_PATTERN;
  endtask : new_img
  // reference: bits in arrival order, packed lsb first into words
  task automatic read_back();
    bit q[$];
    logic [WORD_W-1:0] w;
    for (int i = 0; i < NB; i++) q.push_back(img[i]);
    for (int a = 0; a < NB / WORD_W; a++) begin
      for (int b = 0; b < WORD_W; b++) w[b] = q.pop_front();
      @(posedge clk_i) ra <= 1'(a);
      @(posedge clk_i);
      @(negedge clk_i);
      chk("read_word", rd, w);
    end
  endtask : read_back
  task automatic restart(logic [1:0] o);
    @(posedge clk_i) rcfg <= 1'b0;
    opt <= o;
    repeat (500) begin
      @(posedge clk_i);
      uclk <= ~uclk;
    end
    @(negedge clk_i);
    chk("rcfg_status", st_oe_b, 1'b0);
    chk("rcfg_done", ld_oe_b, 1'b0);
    chk("rcfg_io", io, 3'b110);
    @(posedge clk_i) rcfg <= 1'b1;
  endtask : restart
  // 9 clocks a period keeps the user clock well under its ceiling
  task automatic pulse();
    @(posedge clk_i) uclk <= 1'b1;
    repeat (4) @(posedge clk_i);
    uclk <= 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : pulse
  initial begin
    new_img(1'b1);
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk("por_status", st_oe_b, 1'b0);
    chk("por_io", io, 3'b110);
    wait_sig(0);
    chk("init_done_low", ido, 1'b0);
    chk("chain_out", cen, 1'b0);
    read_back();
    wait_sig(1);
    chk("io_user", io, 3'b001);
    chk("init_done_rel", ido, 1'b1);
    $display("test 1 done");
    new_img(1'b0);
    restart(2'b10);
    wait_sig(0);
    chk("init_done_off", ido, 1'b1);
    read_back();
    repeat (1000) @(posedge clk_i);
    repeat (298) pulse();
    chk("user_early", io.user_mode, 1'b0);
    pulse();
    chk("user_299", io.user_mode, 1'b1);
    $display("test 2 done");
    img[15:0] = ~SYNC_PATTERN;
    restart(2'b01);
    wait_sig(2);
    chk("error", err, 1'b1);
    chk("err_status", st_oe_b, 1'b0);
    new_img(1'b1);
    wait_sig(0);
    read_back();
    wait_sig(1);
    chk("io_user2", io, 3'b001);
    $display("test 3 done");
    final_report();
  end
endmodule : pscl_loader_test
bind pscl_loader pscl_loader_assertions #(.POR_CNT(POR_CNT),
  .RESTART_CNT(RESTART_CNT)) chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .reconfig_b_i(reconfig_b_i), .opt_i(opt_i), .load_done_i(load_done_i),
  .user_startup_clock_i(user_startup_clock_i), .status_o(status_o),
  .load_done_o(load_done_o), .init_done_o(init_done_o),
  .status_oe_b_o(status_oe_b_o), .load_done_oe_b_o(load_done_oe_b_o),
  .init_done_oe_b_o(init_done_oe_b_o),
  .chain_enable_out_low_o(chain_enable_out_low_o), .io_ctrl_o(io_ctrl_o),
  .cfg_error_o(cfg_error_o));
`default_nettype wire
